/* verilog/qc_pkg.sv */
// Shared constants for the quadrature up/down counter and its bus host.
`default_nettype none
package qc_pkg;
   // Clock and timing.
   localparam int unsigned CLK_NS         = 100;
   localparam int unsigned FILT_NS        = 160;
   localparam int unsigned FILT_CYC_RAW   = FILT_NS / CLK_NS;
   localparam int unsigned FILT_CYC       = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
   localparam int unsigned WR_PULSE_NS    = 60;
   // One extra strobe cycle lets the registered read data settle before capture.
   localparam int unsigned STROBE_CYC     = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS + 1;
   // Control write target in data bits 7:6.
   localparam logic [1:0] TGT_MASTER      = 2'h0;
   localparam logic [1:0] TGT_INPUT       = 2'h1;
   localparam logic [1:0] TGT_OUTPUT      = 2'h2;
   localparam logic [1:0] TGT_QUAD        = 2'h3;
   // Master command bits.
   localparam int unsigned MC_RST_PTR     = 0;
   localparam int unsigned MC_CNT_TO_LAT  = 1;
   localparam int unsigned MC_CLR_CNT     = 2;
   localparam int unsigned MC_STG_TO_CNT  = 3;
   localparam int unsigned MC_CLR_FLAGS   = 4;
   // Input config fields.
   localparam int unsigned IC_ABMODE_LSB  = 0;
   localparam int unsigned IC_GATE_LSB    = 2;
   localparam int unsigned IC_LOAD_LATCH  = 4;
   localparam int unsigned IC_SINGLE      = 5;
   localparam logic [1:0] AB_UP_DOWN      = 2'h0;
   localparam logic [1:0] AB_CLK_DIR      = 2'h1;
   localparam logic [1:0] GATE_NONE       = 2'h0;
   localparam logic [1:0] GATE_ENABLE     = 2'h1;
   localparam logic [1:0] GATE_CLEAR      = 2'h2;
   // Output/counter config fields.
   localparam int unsigned OC_MODE_LSB    = 0;
   localparam int unsigned OC_CY_LSB      = 2;
   localparam int unsigned OC_BW_LSB      = 4;
   localparam logic [1:0] MODE_BIN        = 2'h0;
   localparam logic [1:0] MODE_BCD        = 2'h1;
   localparam logic [1:0] MODE_HOUR24     = 2'h2;
   localparam logic [1:0] MODE_DIVN       = 2'h3;
   // Quadrature mode.
   localparam logic [1:0] QUAD_OFF        = 2'h0;
   localparam logic [1:0] QUAD_X1         = 2'h1;
   localparam logic [1:0] QUAD_X2         = 2'h2;
   localparam logic [1:0] QUAD_X4         = 2'h3;
   // Reset values.
   localparam logic [5:0] CFG_RST         = 6'h00;
   localparam logic [23:0] VAL_RST        = 24'h000000;
   localparam logic [7:0] BUS_IDLE        = 8'hFF;
endpackage
`default_nettype wire

/* verilog/qc_bus_if.sv */
// Pins between the counter and its host: 8-bit bus, strobes and count-side lines.
`default_nettype none
interface qc_bus_if;
   logic       cs_n;
   logic       rd_n;
   logic       wr_n;
   logic       cd;
   logic [7:0] host_d;
   logic       host_oe_n;
   logic [7:0] dev_d;
   logic       dev_oe_n;
   logic [7:0] bus;
   logic       enc_a;
   logic       enc_b;
   logic       gate_n;
   logic       load_n;
   logic       carry;
   logic       borrow;
   // Bus level: the device wins while reading, an undriven bus floats high.
   assign bus = !dev_oe_n ? dev_d : (!host_oe_n ? host_d : qc_pkg::BUS_IDLE);
   modport dev (input cs_n, rd_n, wr_n, cd, bus, enc_a, enc_b, gate_n, load_n,
                output dev_d, dev_oe_n, carry, borrow);
   modport host (input bus, carry, borrow,
                 output cs_n, rd_n, wr_n, cd, host_d, host_oe_n,
                 enc_a, enc_b, gate_n, load_n);
endinterface
`default_nettype wire

/* verilog/qc_device.sv */
// Counter end: bus register file, count engine, quadrature filter and outputs.
`default_nettype none
module qc_device (
   input  wire logic   CLOCK_I,
   input  wire logic   RSTN_I,
   qc_bus_if.dev       PINS,
   output logic [23:0] COUNT_O
);
   localparam int unsigned FW = $clog2(qc_pkg::FILT_CYC + 1);

   typedef struct packed {
      logic [5:0]         input_config_reg, output_counter_config_reg;
      logic [1:0]         qr;
      logic [23:0]        stage, cnt, latch;
      logic [1:0]         sptr, lptr;
      logic               wr_d, rd_d;
      logic [1:0]         ab_d, qf;
      logic [1:0][FW-1:0] fcnt;
      logic               load_d, cmp_en, run, up_dir, eq;
      logic               cy_t, bw_t, eq_t, cy_p, bw_p;
      logic [7:0]         dout;
      logic               oe_n, cy_pin, bw_pin;
   } qc_dev_s;

   qc_dev_s s_r;
   qc_dev_s s_nxt;

   // Returns {wrap, next value} for one count step in the selected mode.
   function automatic logic [24:0] qc_step(input logic [23:0] v, input logic up,
                                            input logic [1:0] mode, input logic [23:0] n);
      logic [23:0] r;
      logic        c;
      logic [3:0]  d;
      logic [3:0]  lim;
      r = v;
      c = 1'b1;
      if (mode == qc_pkg::MODE_BIN) begin
         c = up ? (v == 24'hFFFFFF) : (v == 24'h000000);
         r = up ? v + 24'h000001 : v - 24'h000001;
      end else if (mode == qc_pkg::MODE_DIVN) begin
         c = up ? (v == n) : (v == 24'h000000);
         r = c ? (up ? 24'h000000 : n) : (up ? v + 24'h000001 : v - 24'h000001);
      end else begin
         for (int i = 0; i < 6; i++) begin
            d = r[4*i +: 4];
            lim = 4'h9;
            if (mode == qc_pkg::MODE_HOUR24) begin
               if (i == 1 || i == 3) lim = 4'h5;
               if (i == 5) lim = 4'h2;
               if (i == 4 && up && r[23:20] == 4'h2) lim = 4'h3;
            end
            if (c) begin
               if (up) begin
                  c = (d >= lim);
                  d = c ? 4'h0 : d + 4'h1;
               end else begin
                  c = (d == 4'h0);
                  d = c ? lim : d - 4'h1;
               end
            end
            r[4*i +: 4] = d;
         end
         if (mode == qc_pkg::MODE_HOUR24 && !up && c) r[23:16] = 8'h23;
      end
      return {c, r};
   endfunction

   always_comb begin
      logic        wr_act, rd_act, rise_a, rise_b, step, up, gate_ok, edge_clk;
      logic        ld_stage, ld_latch, clr_cnt, ld_pin;
      logic [1:0]  nq, chg, gfn;
      logic [24:0] res;
      logic [7:0]  wd;
      s_nxt    = s_r;
      wd       = PINS.bus;
      rise_a   = 1'b0;
      rise_b   = 1'b0;
      gate_ok  = 1'b1;
      edge_clk = 1'b0;
      ld_pin   = 1'b0;
      nq       = 2'h0;
      chg      = 2'h0;
      res      = '0;
      gfn      = 2'h0;
      wr_act   = !PINS.cs_n && !PINS.wr_n;
      rd_act   = !PINS.cs_n && !PINS.rd_n;
      ld_stage = 1'b0;
      ld_latch = 1'b0;
      clr_cnt  = 1'b0;
      step     = 1'b0;
      up       = s_r.up_dir;
      s_nxt.wr_d = wr_act;
      s_nxt.rd_d = rd_act;
      s_nxt.cy_p = 1'b0;
      s_nxt.bw_p = 1'b0;

      // Each store strobe acts once, at its first active cycle.
      if (wr_act && !s_r.wr_d) begin
         if (PINS.cd) begin
            case (wd[7:6])
               qc_pkg::TGT_MASTER: begin
                  if (wd[qc_pkg::MC_RST_PTR]) begin
                     s_nxt.sptr = 2'h0;
                     s_nxt.lptr = 2'h0;
                  end
                  ld_latch = wd[qc_pkg::MC_CNT_TO_LAT];
                  clr_cnt  = wd[qc_pkg::MC_CLR_CNT];
                  ld_stage = wd[qc_pkg::MC_STG_TO_CNT];
                  if (wd[qc_pkg::MC_CLR_FLAGS]) begin
                     s_nxt.cy_t = 1'b0;
                     s_nxt.bw_t = 1'b0;
                     s_nxt.eq_t = 1'b0;
                  end
               end
               qc_pkg::TGT_INPUT:  s_nxt.input_config_reg = wd[5:0];
               qc_pkg::TGT_OUTPUT: s_nxt.output_counter_config_reg = wd[5:0];
               qc_pkg::TGT_QUAD:   s_nxt.qr = wd[1:0];
               default: ;
            endcase
         end else begin
            s_nxt.stage[8*s_r.sptr +: 8] = wd;
            s_nxt.sptr = (s_r.sptr == 2'h2) ? 2'h0 : s_r.sptr + 2'h1;
         end
      end

      // Read data is captured at the strobe's start and held while it lasts.
      if (rd_act && !s_r.rd_d) begin
         if (PINS.cd) begin
            s_nxt.dout = {3'h0, s_r.eq, s_r.up_dir, s_r.eq_t, s_r.bw_t, s_r.cy_t};
         end else begin
            s_nxt.dout = s_r.latch[8*s_r.lptr +: 8];
            s_nxt.lptr = (s_r.lptr == 2'h2) ? 2'h0 : s_r.lptr + 2'h1;
         end
      end
      s_nxt.oe_n = !rd_act;

      // Load pin acts on its falling edge.
      s_nxt.load_d = PINS.load_n;
      ld_pin = s_r.load_d && !PINS.load_n;
      if (ld_pin) begin
         if (s_r.input_config_reg[qc_pkg::IC_LOAD_LATCH]) ld_latch = 1'b1;
         else ld_stage = 1'b1;
      end

      gfn = s_r.input_config_reg[qc_pkg::IC_GATE_LSB +: 2];
      gate_ok = !(gfn == qc_pkg::GATE_ENABLE && PINS.gate_n);

      s_nxt.ab_d = {PINS.enc_a, PINS.enc_b};
      rise_a = PINS.enc_a && !s_r.ab_d[1];
      rise_b = PINS.enc_b && !s_r.ab_d[0];

      for (int i = 0; i < 2; i++) begin
         nq[i] = s_r.qf[i];
         s_nxt.fcnt[i] = '0;
         if (s_nxt.ab_d[i] != s_r.qf[i]) begin
            if (s_r.fcnt[i] >= FW'(qc_pkg::FILT_CYC - 1)) nq[i] = s_nxt.ab_d[i];
            else s_nxt.fcnt[i] = s_r.fcnt[i] + FW'(1);
         end
      end
      s_nxt.qf = nq;
      chg = nq ^ s_r.qf;

      if (s_r.qr != qc_pkg::QUAD_OFF) begin
         edge_clk = |chg;
         if (chg == 2'b10 || chg == 2'b01) begin
            up = nq[1] ^ s_r.qf[0];
            case (s_r.qr)
               qc_pkg::QUAD_X4: step = 1'b1;
               qc_pkg::QUAD_X2: step = chg[1];
               default:         step = chg[1] && (up == nq[1]);
            endcase
         end
      end else begin
         edge_clk = rise_a || rise_b;
         if (s_r.input_config_reg[1:0] == qc_pkg::AB_CLK_DIR) begin
            step = rise_a;
            up   = !PINS.enc_b;
         end else begin
            step = rise_a ^ rise_b;
            up   = rise_a;
         end
      end

      if (step && gate_ok && (s_r.run || !s_r.input_config_reg[qc_pkg::IC_SINGLE])) begin
         res = qc_step(s_r.cnt, up, s_r.output_counter_config_reg[qc_pkg::OC_MODE_LSB +: 2], s_r.stage);
         s_nxt.cnt = res[23:0];
         s_nxt.up_dir = up;
         if (res[24]) begin
            s_nxt.cy_p = up;
            s_nxt.bw_p = !up;
            if (up) s_nxt.cy_t = !s_nxt.cy_t;
            else s_nxt.bw_t = !s_nxt.bw_t;
            if (s_r.input_config_reg[qc_pkg::IC_SINGLE]) s_nxt.run = 1'b0;
         end
      end
      if (edge_clk) s_nxt.cmp_en = 1'b1;

      if (ld_latch) s_nxt.latch = s_r.cnt;
      if (ld_stage) begin
         s_nxt.cnt = s_r.stage;
         s_nxt.cmp_en = 1'b0;
         s_nxt.run = 1'b1;
      end
      if (clr_cnt || (gfn == qc_pkg::GATE_CLEAR && !PINS.gate_n))
         s_nxt.cnt = qc_pkg::VAL_RST;

      s_nxt.eq = s_r.cmp_en && (s_r.cnt == s_r.stage);
      if (s_nxt.eq && !s_r.eq) s_nxt.eq_t = !s_nxt.eq_t;

      case (s_r.output_counter_config_reg[qc_pkg::OC_CY_LSB +: 2])
         2'h0:    s_nxt.cy_pin = !s_nxt.cy_p;
         2'h1:    s_nxt.cy_pin = s_nxt.cy_p;
         2'h2:    s_nxt.cy_pin = s_nxt.cy_t;
         default: s_nxt.cy_pin = !s_nxt.eq;
      endcase
      case (s_r.output_counter_config_reg[qc_pkg::OC_BW_LSB +: 2])
         2'h0:    s_nxt.bw_pin = !s_nxt.bw_p;
         2'h1:    s_nxt.bw_pin = s_nxt.bw_p;
         2'h2:    s_nxt.bw_pin = s_nxt.bw_t;
         default: s_nxt.bw_pin = s_nxt.eq_t;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         s_r        <= '0;
         s_r.wr_d   <= 1'b1;
         s_r.rd_d   <= 1'b1;
         s_r.load_d <= 1'b1;
         s_r.ab_d   <= 2'h3;
         s_r.qf     <= 2'h3;
         s_r.run    <= 1'b1;
         s_r.up_dir <= 1'b1;
         s_r.dout   <= qc_pkg::BUS_IDLE;
         s_r.oe_n   <= 1'b1;
         s_r.cy_pin <= 1'b1;
         s_r.bw_pin <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign PINS.dev_d    = s_r.dout;
   assign PINS.dev_oe_n = s_r.oe_n;
   assign PINS.carry    = s_r.cy_pin;
   assign PINS.borrow   = s_r.bw_pin;
   assign COUNT_O       = s_r.cnt;
endmodule
`default_nettype wire

/* verilog/qc_host.sv */
// Host end: turns single bus commands into strobe cycles and drives the count lines.
`default_nettype none
module qc_host (
   input  wire logic       CLOCK_I,
   input  wire logic       RSTN_I,
   qc_bus_if.host          PINS,
   input  wire logic       CMD_VALID_I,
   input  wire logic       CMD_WRITE_I,
   input  wire logic       CMD_CD_I,
   input  wire logic [7:0] CMD_DATA_I,
   output logic            CMD_READY_O,
   output logic            RSP_VALID_O,
   output logic [7:0]      RSP_DATA_O,
   input  wire logic       ENC_A_I,
   input  wire logic       ENC_B_I,
   input  wire logic       GATE_N_I,
   input  wire logic       LOAD_N_I,
   output logic            CARRY_O,
   output logic            BORROW_O
);
   localparam int unsigned SW = $clog2(qc_pkg::STROBE_CYC + 1);

   typedef enum logic [1:0] {QC_IDLE, QC_SETUP, QC_STROBE, QC_HOLD} qc_host_e;

   typedef struct packed {
      qc_host_e    st;
      logic [SW-1:0] cyc;
      logic        wr;
      logic        cs_n;
      logic        rd_n;
      logic        wr_n;
      logic        cd;
      logic [7:0]  d;
      logic        oe_n;
      logic        ready;
      logic        rsp_v;
      logic [7:0]  rsp_d;
      logic [3:0]  enc;
      logic [1:0]  outs;
   } qc_host_s;

   qc_host_s h_r;
   qc_host_s h_nxt;

   always_comb begin
      h_nxt       = h_r;
      h_nxt.rsp_v = 1'b0;
      h_nxt.enc   = {ENC_A_I, ENC_B_I, GATE_N_I, LOAD_N_I};
      h_nxt.outs  = {PINS.carry, PINS.borrow};
      case (h_r.st)
         QC_IDLE: begin
            if (CMD_VALID_I) begin
               h_nxt.st    = QC_SETUP;
               h_nxt.ready = 1'b0;
               h_nxt.wr    = CMD_WRITE_I;
               h_nxt.cs_n  = 1'b0;
               h_nxt.cd    = CMD_CD_I;
               h_nxt.d     = CMD_DATA_I;
               h_nxt.oe_n  = !CMD_WRITE_I;
            end
         end
         QC_SETUP: begin
            h_nxt.st   = QC_STROBE;
            h_nxt.cyc  = '0;
            h_nxt.wr_n = !h_r.wr;
            h_nxt.rd_n = h_r.wr;
         end
         QC_STROBE: begin
            h_nxt.cyc = h_r.cyc + SW'(1);
            if (h_r.cyc == SW'(qc_pkg::STROBE_CYC - 1)) begin
               h_nxt.st   = QC_HOLD;
               h_nxt.wr_n = 1'b1;
               h_nxt.rd_n = 1'b1;
               if (!h_r.wr) begin
                  h_nxt.rsp_v = 1'b1;
                  h_nxt.rsp_d = PINS.bus;
               end
            end
         end
         QC_HOLD: begin
            h_nxt.st    = QC_IDLE;
            h_nxt.cs_n  = 1'b1;
            h_nxt.oe_n  = 1'b1;
            h_nxt.ready = 1'b1;
         end
         default: h_nxt.st = QC_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         h_r       <= '0;
         h_r.st    <= QC_IDLE;
         h_r.cs_n  <= 1'b1;
         h_r.rd_n  <= 1'b1;
         h_r.wr_n  <= 1'b1;
         h_r.oe_n  <= 1'b1;
         h_r.ready <= 1'b1;
         h_r.enc   <= 4'hF;
         h_r.outs  <= 2'h3;
      end else begin
         h_r <= h_nxt;
      end
   end

   assign PINS.cs_n      = h_r.cs_n;
   assign PINS.rd_n      = h_r.rd_n;
   assign PINS.wr_n      = h_r.wr_n;
   assign PINS.cd        = h_r.cd;
   assign PINS.host_d    = h_r.d;
   assign PINS.host_oe_n = h_r.oe_n;
   assign PINS.enc_a     = h_r.enc[3];
   assign PINS.enc_b     = h_r.enc[2];
   assign PINS.gate_n    = h_r.enc[1];
   assign PINS.load_n    = h_r.enc[0];
   assign CMD_READY_O    = h_r.ready;
   assign RSP_VALID_O    = h_r.rsp_v;
   assign RSP_DATA_O     = h_r.rsp_d;
   assign CARRY_O        = h_r.outs[1];
   assign BORROW_O       = h_r.outs[0];
endmodule
`default_nettype wire

/* sim/qc_pins_checker.sv */
// Concurrent checks on the pins that join the counter and its host.
`default_nettype none
module qc_pins_checker (
   input  wire logic        CLOCK_I,
   input  wire logic        RSTN_I,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        cd,
   input  wire logic        host_oe_n,
   input  wire logic [7:0]  dev_d,
   input  wire logic        dev_oe_n,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic        gate_n,
   input  wire logic        load_n,
   input  wire logic [23:0] COUNT_O
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] pins_r;
   logic       moved;
   logic       rd_act;
   assign moved  = pins_r != {enc_a, enc_b, gate_n, load_n};
   assign rd_act = !cs_n && !rd_n;
   // Remembers the count-side pins so that any change of them can be seen.
   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pins_r <= 4'hF;
      end else begin
         pins_r <= {enc_a, enc_b, gate_n, load_n};
      end
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RSTN_I);
   property p_drive_needs_read; !dev_oe_n |-> $past(rd_act) || $past(rd_act, 2); endproperty
   a_drive_needs_read: assert property (p_drive_needs_read) else $error("Bus driven outside a read");
   property p_read_answers; $fell(rd_n) && !cs_n |-> ##[0:2] !dev_oe_n; endproperty
   a_read_answers: assert property (p_read_answers) else $error("Read got no bus drive");
   property p_oe_release; $rose(rd_n) |-> ##[0:2] dev_oe_n; endproperty
   a_oe_release: assert property (p_oe_release) else $error("Bus not released after read");
   property p_idle_float; cs_n && $past(cs_n) && $past(cs_n, 2) |-> dev_oe_n; endproperty
   a_idle_float: assert property (p_idle_float) else $error("Bus driven while deselected");
   property p_status_top; !dev_oe_n && cd |-> dev_d[7:5] == 3'h0; endproperty
   a_status_top: assert property (p_status_top) else $error("Status upper bits not zero");
   property p_read_stable; !dev_oe_n && $past(dev_oe_n) == 1'b0 |-> $stable(dev_d); endproperty
   a_read_stable: assert property (p_read_stable) else $error("Read data moved mid read");
   property p_strobe_cs; !rd_n || !wr_n |-> !cs_n; endproperty
   a_strobe_cs: assert property (p_strobe_cs) else $error("Strobe without chip select");
   property p_write_drives; !wr_n |-> !host_oe_n && dev_oe_n; endproperty
   a_write_drives: assert property (p_write_drives) else $error("Bus owner wrong in write");
   property p_cd_steady; !cs_n && $past(cs_n) == 1'b0 |-> $stable(cd); endproperty
   a_cd_steady: assert property (p_cd_steady) else $error("Select moved in access");
   property p_count_cause;
      $changed(COUNT_O) |-> $past(moved) || $past(moved, 2) || $past(moved, 3)
         || $past(moved, 4) || $past(moved, 5) || !$past(wr_n) || !$past(wr_n, 2);
   endproperty
   a_count_cause: assert property (p_count_cause) else $error("Count moved without cause");
endmodule
`default_nettype wire

/* sim/quadrature_up_down_counter_24b_test.sv */
// Self-checking bench: host and counter joined over their pin interface.
`default_nettype none
module quadrature_up_down_counter_24b_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk;
   logic        rstn;
   logic        valid;
   logic        write;
   logic        cd;
   logic [7:0]  data;
   logic        ready;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic        enc_a;
   logic        enc_b;
   logic        gate_n;
   logic        load_n;
   logic        carry;
   logic        borrow;
   logic [23:0] count;
   int          n_errors;
   int          tests_run;
   qc_bus_if pins ();
   qc_device qc_device_inst (.CLOCK_I(clk), .RSTN_I(rstn), .PINS(pins), .COUNT_O(count));
   qc_host qc_host_inst (.CLOCK_I(clk), .RSTN_I(rstn), .PINS(pins), .CMD_VALID_I(valid),
      .CMD_WRITE_I(write), .CMD_CD_I(cd), .CMD_DATA_I(data), .CMD_READY_O(ready),
      .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data), .ENC_A_I(enc_a), .ENC_B_I(enc_b),
      .GATE_N_I(gate_n), .LOAD_N_I(load_n), .CARRY_O(carry), .BORROW_O(borrow));
   qc_pins_checker qc_pins_checker_inst (.CLOCK_I(clk), .RSTN_I(rstn), .cs_n(pins.cs_n),
      .rd_n(pins.rd_n), .wr_n(pins.wr_n), .cd(pins.cd), .host_oe_n(pins.host_oe_n),
      .dev_d(pins.dev_d), .dev_oe_n(pins.dev_oe_n), .enc_a(pins.enc_a), .enc_b(pins.enc_b),
      .gate_n(pins.gate_n), .load_n(pins.load_n), .COUNT_O(count));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Called at a falling edge; returns at a falling edge with the host idle.
   task automatic wait_ready();
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      if (ready !== 1'b1) begin
         check({23'h0, ready}, 24'h1);
         finish_test();
      end
   endtask
   task automatic acc(input logic w, input logic c, input logic [7:0] d);
      @(negedge clk);
      wait_ready();
      valid = 1'b1;
      write = w;
      cd = c;
      data = d;
      @(negedge clk);
      valid = 1'b0;
      @(negedge clk);
      wait_ready();
   endtask
   // Plays nibbles {a, b, gate_n, load_n} from the most significant one used.
   task automatic play(input logic [31:0] seq, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk);
         {enc_a, enc_b, gate_n, load_n} = seq[4*i +: 4];
         repeat (4) @(negedge clk);
      end
   endtask
   initial begin
      logic [23:0] lat;
      rstn = 1'b0;
      valid = 1'b0;
      write = 1'b0;
      cd = 1'b0;
      data = 8'h00;
      {enc_a, enc_b, gate_n, load_n} = 4'hF;
      n_errors = 0;
      tests_run = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      check({22'h0, carry, borrow}, 24'h3);
      acc(1, 1, 8'h01);
      acc(1, 0, 8'hAA);
      acc(1, 1, 8'h01);
      acc(1, 0, 8'h11);
      acc(1, 0, 8'h22);
      acc(1, 0, 8'h33);
      acc(1, 1, 8'h08);
      check(count, 24'h332211);
      acc(1, 0, 8'h99);
      acc(1, 1, 8'h05);
      check(count, 24'h000000);
      acc(1, 0, 8'h66);
      acc(1, 1, 8'h08);
      check(count, 24'h332266);
      $display("Test staging and commands done");
      acc(1, 1, 8'h03);
      play(32'h7F, 2);
      check(count, 24'h332267);
      play(32'hBF, 2);
      check(count, 24'h332266);
      lat = 24'h332266;
      for (int i = 0; i < 4; i++) begin
         acc(0, 0, 8'h00);
         check({16'h0, rsp_data}, (lat >> (8 * (i % 3))) & 24'hFF);
      end
      $display("Test snapshot done");
      play(32'h7F, 2);
      play(32'hEF, 2);
      check(count, 24'h332266);
      acc(0, 1, 8'h00);
      check({16'h0, rsp_data & 8'hF8}, 24'h08);
      play(32'h7FBF, 4);
      acc(0, 1, 8'h00);
      check({16'h0, rsp_data & 8'hF8}, 24'h10);
      $display("Test load pin and status done");
      acc(1, 1, 8'h41);
      play(32'hB3B, 3);
      check(count, 24'h332267);
      play(32'hF7F, 3);
      check(count, 24'h332266);
      $display("Test direction input done");
      for (int m = 1; m < 4; m++) begin
         acc(1, 1, 8'hC0 | 8'(m));
         play(32'h73BF, 4);
         check(count, 24'h332266 + (24'h1 << (m - 1)));
         play(32'hB37F, 4);
         check(count, 24'h332266);
      end
      acc(1, 1, 8'hC0);
      $display("Test quadrature done");
      acc(1, 1, 8'h48);
      play(32'hDF, 2);
      check(count, 24'h000000);
      acc(1, 1, 8'h44);
      play(32'h7F, 2);
      check(count, 24'h000000);
      play(32'hD5DF, 4);
      check(count, 24'h000001);
      $display("Test gate input done");
      acc(1, 1, 8'h40);
      acc(1, 1, 8'h01);
      acc(1, 0, 8'h09);
      acc(1, 0, 8'h00);
      acc(1, 0, 8'h00);
      acc(1, 1, 8'h08);
      acc(1, 1, 8'h81);
      play(32'h7F, 2);
      check(count, 24'h000010);
      $display("Test decimal mode done");
      acc(1, 1, 8'hA8);
      acc(1, 1, 8'h01);
      for (int i = 0; i < 3; i++) begin
         acc(1, 0, 8'hFF);
      end
      acc(1, 1, 8'h18);
      play(32'h7F, 2);
      check(count, 24'h000000);
      check({22'h0, carry, borrow}, 24'h2);
      play(32'hBF, 2);
      check(count, 24'hFFFFFF);
      check({22'h0, carry, borrow}, 24'h3);
      acc(0, 1, 8'h00);
      check({16'h0, rsp_data}, 24'h17);
      acc(1, 1, 8'hBC);
      check({22'h0, carry, borrow}, 24'h1);
      $display("Test output pins done");
      acc(1, 1, 8'h82);
      acc(1, 1, 8'h04);
      play(32'hBF, 2);
      check(count, 24'h235959);
      acc(1, 1, 8'h50);
      play(32'hEF, 2);
      acc(1, 1, 8'h01);
      acc(0, 0, 8'h00);
      check({16'h0, rsp_data}, 24'h59);
      play(32'h7F, 2);
      check(count, 24'h000000);
      $display("Test 24-hour mode and latch pin done");
      acc(1, 1, 8'h83);
      acc(1, 1, 8'h01);
      acc(1, 0, 8'h02);
      acc(1, 0, 8'h00);
      acc(1, 0, 8'h00);
      play(32'h7F7F, 4);
      check(count, 24'h000002);
      play(32'h7F, 2);
      check(count, 24'h000000);
      acc(1, 1, 8'h60);
      play(32'h7F7F7F7F, 8);
      check(count, 24'h000000);
      acc(1, 1, 8'h08);
      play(32'h7F, 2);
      check(count, 24'h000000);
      $display("Test divide-by-N and single-cycle done");
      finish_test();
   end
endmodule
`default_nettype wire
